// ===== cdp_pkg.sv
package cdp_pkg;

    // ************************************************************
    // Widths of the data pins and of the words handed to the core
    // ************************************************************
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int BIT_CNT_W = 3;

    // ************************************************************
    // Timing of the self-driven configuration clock
    // ************************************************************
    localparam int CLK_FREQ_HZ = 50_000_000;
    localparam int ACTIVE_CLK_HZ = 6_250_000;
    // Half period in core cycles; at least 3 so the pin synchroniser settles
    localparam int HALF_DIV = CLK_FREQ_HZ / (2 * ACTIVE_CLK_HZ);
    localparam int DIV_W = 8;

    // ************************************************************
    // Active serial read request shifted out before data returns
    // ************************************************************
    localparam int CMD_W = 32;
    localparam logic [31:0] AS_READ_CMD = 32'h0300_0000;
    localparam logic [5:0] CMD_LEN = 6'h20;

    // ************************************************************
    // Reset values and the last bit count
    // ************************************************************
    localparam logic [15:0] DATA_RST = 16'h0000;
    localparam logic [2:0] BIT_RST = 3'h0;
    localparam logic [2:0] BIT_LAST = 3'h7;

    // Configuration schemes, fixed for a whole load
    typedef enum logic [1:0] {
        CDP_PASSIVE_SERIAL_SCHEME,
        CDP_FAST_PASSIVE_PARALLEL_SCHEME,
        CDP_ACTIVE_SERIAL_SCHEME,
        CDP_ACTIVE_PARALLEL_SCHEME
    } cdp_scheme_type;

    // Load sequence
    typedef enum logic [1:0] {
        CDP_IDLE,
        CDP_LOAD,
        CDP_USER
    } cdp_state_type;

    // One received unit: a byte in the low bits, or a full word when wide
    typedef struct packed {
        logic [15:0] data;
        logic wide;
    } cdp_word_type;

endpackage : cdp_pkg

// ===== cdp_pair_buffer.sv
module cdp_pair_buffer #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 2
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);

    // ************************************************************
    // Storage and pointers
    // ************************************************************
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem [DEPTH];  // Entries in flip-flops
    logic [PTR_W-1:0] wr_ptr;       // Next slot to fill
    logic [PTR_W-1:0] rd_ptr;       // Oldest slot
    logic [PTR_W:0] count;          // Occupancy
    logic do_wr;
    logic do_rd;

    assign in_ready_o = (count != (PTR_W + 1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o = mem[rd_ptr];
    assign do_wr = in_valid_i && in_ready_o;
    assign do_rd = out_valid_o && out_ready_i;

    // Write side
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_ptr <= '0;
        end else if (do_wr) begin
            wr_ptr <= (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + PTR_W'(1);
        end
    end

    // Entries carry no reset; valid is held by the count
    always_ff @(posedge clk_i) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    // Read side
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_ptr <= '0;
        end else if (do_rd) begin
            rd_ptr <= (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + PTR_W'(1);
        end
    end

    // Occupancy, simultaneous read and write leaves it unchanged
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            count <= '0;
        end else if (do_wr && !do_rd) begin
            count <= count + (PTR_W + 1)'(1);
        end else if (do_rd && !do_wr) begin
            count <= count - (PTR_W + 1)'(1);
        end
    end

endmodule : cdp_pair_buffer

// ===== cdp_link_capture.sv
module cdp_link_capture (
    input wire logic link_clk_i,
    input wire logic nrst_i,
    input wire logic enable_i,
    input wire cdp_pkg::cdp_scheme_type scheme_i,
    input wire logic [15:0] data_i,
    output cdp_pkg::cdp_word_type word_o,
    output logic toggle_o
);

    // ************************************************************
    // Enable crossing into the link clock
    // ************************************************************
    logic en_s1;  // First stage, read only by en_s2
    logic en_s2;  // Safe enable
    logic [7:0] shift;
    logic [2:0] bit_cnt;

    // The link clock may stop after a load; the level simply freezes
    always_ff @(posedge link_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            en_s1 <= 1'b0;
            en_s2 <= 1'b0;
        end else begin
            en_s1 <= enable_i;
            en_s2 <= en_s1;
        end
    end

    // ************************************************************
    // Capture on each rising link edge
    // ************************************************************
    // R1 rising edge capture
    always_ff @(posedge link_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            shift <= 8'h00;
            bit_cnt <= cdp_pkg::BIT_RST;
            word_o <= '0;
            toggle_o <= 1'b0;
        end else if (!en_s2) begin
            // R7 edges ignored outside load
            bit_cnt <= cdp_pkg::BIT_RST;
        end else if (scheme_i == cdp_pkg::CDP_PASSIVE_SERIAL_SCHEME) begin
            // R8 serial bits on pin zero, low bit first
            shift <= {data_i[0], shift[7:1]};
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == cdp_pkg::BIT_LAST) begin
                word_o <= '{data: {8'h00, data_i[0], shift[7:1]}, wide: 1'b0};
                toggle_o <= ~toggle_o;
            end
        end else begin
            // R9 byte per edge on low pins
            word_o <= '{data: {8'h00, data_i[7:0]}, wide: 1'b0};
            toggle_o <= ~toggle_o;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge link_clk_i); endclocking
    default disable iff (!nrst_i);

    chk_ps_byte_done: assert property ( // R1
        en_s2 && scheme_i == cdp_pkg::CDP_PASSIVE_SERIAL_SCHEME && bit_cnt == 3'h7
        |=> toggle_o != $past(toggle_o) && word_o.data[7] == $past(data_i[0]))
        else $error("serial byte not delivered on eighth edge");
    chk_idle_no_word: assert property ( // R7
        !en_s2 |=> $stable(toggle_o))
        else $error("word delivered while link disabled");

endmodule : cdp_link_capture

// ===== cdp_config_pins.sv
// Operation
// R1 - Passive schemes capture on rising link edges
// R2 - Active schemes drive the configuration clock
// R3 - Active schemes: core may drive clock later
// R4 - Clock pin floats after configuration
// R5 - Configuration device parks clock low afterwards
// R6 - Host holds clock steady after configuration
// R7 - Clock toggling after configuration is ignored
// R8 - Serial schemes use data pin zero
// R9 - Bytes on pins 7..0, words 15..0
// R10 - Active serial drives read request out
// R11 - After active serial, pin zero input
// R12 - After active serial, pin one output
// R13 - Passive serial: pin one floats throughout; the code hands it to user_data_oe_i after configuration
// R14 - Serial schemes: pins seven..two float
// R15 - Passive pins released per shared setting
// R16 - After active parallel, low byte bidirectional
// R17 - Complete flag released only after clean load
// R18 - Scheme fixed from start until completion
module cdp_config_pins #(
    parameter int HALF_DIV = cdp_pkg::HALF_DIV
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic config_data_clock_i,
    input wire logic [1:0] scheme_i,
    input wire logic config_start_i,
    input wire logic load_done_i,
    input wire logic dual_purpose_user_i,
    input wire logic user_clock_en_i,
    input wire logic user_clock_i,
    input wire logic [15:0] user_data_out_i,
    input wire logic [15:0] user_data_oe_i,
    input wire logic [15:0] data_i,
    output logic config_data_clock_o,
    output logic config_data_clock_oe_o,
    output logic [15:0] data_o,
    output logic [15:0] data_oe_o,
    output logic config_complete_flag_o,
    output logic config_complete_flag_oe_o,
    output logic word_valid_o,
    input wire logic word_ready_i,
    output cdp_pkg::cdp_word_type word_o,
    output logic overrun_o,
    output logic loading_o
);

    // ************************************************************
    // Declarations
    // ************************************************************
    cdp_pkg::cdp_state_type st;         // Load sequence state
    cdp_pkg::cdp_scheme_type scheme;    // Scheme held for the load
    logic [1:0] scheme_s1;              // Strap synchroniser, first stage
    logic [1:0] scheme_s2;              // Strap synchroniser, safe
    logic [15:0] pin_s1;                // Data pin synchroniser, first stage
    logic [15:0] pin_s2;                // Data pin synchroniser, safe
    logic is_active;                    // Device makes the clock
    logic link_en;                      // Passive capture enable
    cdp_pkg::cdp_word_type link_word;   // Word held in the link domain
    logic link_tog;                     // Word event from the link
    logic tog_s1;
    logic tog_s2;
    logic tog_s3;
    logic link_evt;                     // One pulse per passive word
    logic [cdp_pkg::DIV_W-1:0] div_cnt; // Half period counter
    logic clk_lvl;                      // Level of the made clock
    logic tick;
    logic active_run;
    logic rise;
    logic fall;
    logic [31:0] cmd_sh;                // Read request being sent
    logic [5:0] cmd_cnt;                // Request bits clocked so far
    logic [7:0] as_sh;                  // Serial data assembly
    logic [2:0] as_cnt;
    logic push_valid;                   // Word waiting for the buffer
    cdp_pkg::cdp_word_type push_word;
    logic buf_ready;
    logic stall;

    assign is_active = (scheme == cdp_pkg::CDP_ACTIVE_SERIAL_SCHEME)
                    || (scheme == cdp_pkg::CDP_ACTIVE_PARALLEL_SCHEME);
    assign link_evt = tog_s2 ^ tog_s3;
    assign stall = push_valid && !buf_ready;
    assign tick = (div_cnt == cdp_pkg::DIV_W'(HALF_DIV - 1));
    assign active_run = (st == cdp_pkg::CDP_LOAD) && is_active && !stall;
    assign rise = active_run && tick && !clk_lvl;
    assign fall = active_run && tick && clk_lvl;

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    // Strap and data pins each pass two stages
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            scheme_s1 <= 2'h0;
            scheme_s2 <= 2'h0;
            pin_s1 <= cdp_pkg::DATA_RST;
            pin_s2 <= cdp_pkg::DATA_RST;
        end else begin
            scheme_s1 <= scheme_i;
            scheme_s2 <= scheme_s1;
            pin_s1 <= data_i;
            pin_s2 <= pin_s1;
        end
    end

    // Link toggle crossing; only the second and third stages are compared
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tog_s1 <= 1'b0;
            tog_s2 <= 1'b0;
            tog_s3 <= 1'b0;
        end else begin
            tog_s1 <= link_tog;
            tog_s2 <= tog_s1;
            tog_s3 <= tog_s2;
        end
    end

    // ************************************************************
    // Load sequence
    // ************************************************************
    // R18 scheme caught at start only
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st <= cdp_pkg::CDP_IDLE;
            scheme <= cdp_pkg::CDP_PASSIVE_SERIAL_SCHEME;
        end else begin
            case (st)
                cdp_pkg::CDP_IDLE: begin
                    if (config_start_i) begin
                        st <= cdp_pkg::CDP_LOAD;
                        scheme <= cdp_pkg::cdp_scheme_type'(scheme_s2);
                    end
                end
                cdp_pkg::CDP_LOAD: begin
                    // R17 leave only when load_done_i is set and no word waits for the buffer
                    if (load_done_i && !push_valid) begin
                        st <= cdp_pkg::CDP_USER;
                    end
                end
                default: begin
                    st <= cdp_pkg::CDP_USER;
                end
            endcase
        end
    end

    // Passive enable; the link side waits for the crossing
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            link_en <= 1'b0;
        end else begin
            link_en <= (st == cdp_pkg::CDP_LOAD) && !is_active;
        end
    end

    // ************************************************************
    // Self-made configuration clock
    // ************************************************************
    // R2 divider makes the clock
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            div_cnt <= '0;
        end else if (!active_run || tick) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + cdp_pkg::DIV_W'(1);
        end
    end

    // Clock holds while the buffer stalls, so no word is lost in an active scheme
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            clk_lvl <= 1'b0;
        end else if (st != cdp_pkg::CDP_LOAD) begin
            clk_lvl <= 1'b0;
        end else if (rise || fall) begin
            clk_lvl <= ~clk_lvl;
        end
    end

    // R10 read request on pin one
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cmd_sh <= cdp_pkg::AS_READ_CMD;
            cmd_cnt <= 6'h00;
        end else if (st == cdp_pkg::CDP_IDLE) begin
            cmd_sh <= cdp_pkg::AS_READ_CMD;
            cmd_cnt <= 6'h00;
        end else if (rise && cmd_cnt != cdp_pkg::CMD_LEN) begin
            cmd_cnt <= cmd_cnt + 6'h01;
        end else if (fall && cmd_cnt != cdp_pkg::CMD_LEN) begin
            cmd_sh <= {cmd_sh[30:0], 1'b0};
        end
    end

    // ************************************************************
    // Word assembly toward the buffer
    // ************************************************************
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            as_sh <= 8'h00;
            as_cnt <= cdp_pkg::BIT_RST;
            push_valid <= 1'b0;
            push_word <= '0;
            overrun_o <= 1'b0;
        end else begin
            if (push_valid && buf_ready) begin
                push_valid <= 1'b0;
            end
            if (st == cdp_pkg::CDP_IDLE) begin
                as_cnt <= cdp_pkg::BIT_RST;
            end else if (link_evt && st == cdp_pkg::CDP_LOAD && !is_active) begin
                // R1 passive word from link
                push_valid <= 1'b1;
                push_word <= link_word;
                if (stall) begin
                    overrun_o <= 1'b1;
                end
            end else if (rise && scheme == cdp_pkg::CDP_ACTIVE_PARALLEL_SCHEME) begin
                // R9 word per edge
                push_valid <= 1'b1;
                push_word <= '{data: pin_s2, wide: 1'b1};
            end else if (rise && cmd_cnt == cdp_pkg::CMD_LEN) begin
                // R8 serial bits on pin zero
                as_sh <= {pin_s2[0], as_sh[7:1]};
                as_cnt <= as_cnt + 3'h1;
                if (as_cnt == cdp_pkg::BIT_LAST) begin
                    push_valid <= 1'b1;
                    push_word <= '{data: {8'h00, pin_s2[0], as_sh[7:1]}, wide: 1'b0};
                end
            end
        end
    end

    // ************************************************************
    // Pin drivers
    // ************************************************************
    // Clock pin and complete flag
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            config_data_clock_o <= 1'b0;
            config_data_clock_oe_o <= 1'b0;
            config_complete_flag_o <= 1'b0;
            config_complete_flag_oe_o <= 1'b1;
            loading_o <= 1'b0;
        end else begin
            loading_o <= (st == cdp_pkg::CDP_LOAD);
            // R17 low until clean load ends
            config_complete_flag_oe_o <= (st != cdp_pkg::CDP_USER);
            if (st == cdp_pkg::CDP_LOAD) begin
                // R2 driven only in active schemes
                config_data_clock_o <= clk_lvl;
                config_data_clock_oe_o <= is_active;
            end else begin
                // R3 optional core control, R4 otherwise floating
                config_data_clock_o <= user_clock_i;
                config_data_clock_oe_o <= (st == cdp_pkg::CDP_USER) && is_active
                                       && user_clock_en_i;
            end
        end
    end

    // Data pins, one driver per bit
    for (genvar b = 0; b < cdp_pkg::DATA_W; b++) begin : g_pin
        // Pins carrying configuration data in a passive scheme
        logic used_passive;
        assign used_passive = (b == 0) || (b < cdp_pkg::BYTE_W
                           && scheme == cdp_pkg::CDP_FAST_PASSIVE_PARALLEL_SCHEME);

        always_ff @(posedge clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
                data_o[b] <= 1'b0;
                data_oe_o[b] <= 1'b0;
            end else if (st == cdp_pkg::CDP_LOAD) begin
                // R13 R14 only the request pin drives in a load
                data_o[b] <= cmd_sh[31];
                data_oe_o[b] <= (b == 1) && scheme == cdp_pkg::CDP_ACTIVE_SERIAL_SCHEME;
            end else if (st == cdp_pkg::CDP_USER) begin
                data_o[b] <= user_data_out_i[b];
                if (scheme == cdp_pkg::CDP_ACTIVE_SERIAL_SCHEME && b == 0) begin
                    // R11 input only
                    data_oe_o[b] <= 1'b0;
                end else if (!is_active && used_passive) begin
                    // R15 shared-pin setting decides
                    data_oe_o[b] <= dual_purpose_user_i && user_data_oe_i[b];
                end else begin
                    // R12 R16 core control of dedicated pins
                    data_oe_o[b] <= user_data_oe_i[b];
                end
            end else begin
                data_o[b] <= 1'b0;
                data_oe_o[b] <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Leaf instances
    // ************************************************************
    cdp_link_capture u_link (
        .link_clk_i(config_data_clock_i),
        .nrst_i(nrst_i),
        .enable_i(link_en),
        .scheme_i(scheme),
        .data_i(data_i),
        .word_o(link_word),
        .toggle_o(link_tog)
    );

    cdp_pair_buffer #(
        .WIDTH($bits(cdp_pkg::cdp_word_type)),
        .DEPTH(2)
    ) u_buf (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .in_valid_i(push_valid),
        .in_ready_o(buf_ready),
        .in_data_i(push_word),
        .out_valid_o(word_valid_o),
        .out_ready_i(word_ready_i),
        .out_data_o(word_o)
    );

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    chk_clock_drive_load: assert property ( // R2
        st == cdp_pkg::CDP_LOAD && $past(st) == cdp_pkg::CDP_LOAD
        |-> config_data_clock_oe_o == is_active)
        else $error("clock drive wrong during load");
    chk_clock_float_user: assert property ( // R4
        $past(st) == cdp_pkg::CDP_USER && !$past(user_clock_en_i) |-> !config_data_clock_oe_o)
        else $error("clock pin driven after configuration");
    chk_user_no_words: assert property ( // R7
        st == cdp_pkg::CDP_USER |=> !push_valid || $stable(push_word))
        else $error("word taken after configuration");
    chk_request_pin: assert property ( // R10
        $past(st) == cdp_pkg::CDP_LOAD && scheme == cdp_pkg::CDP_ACTIVE_SERIAL_SCHEME
        |-> data_oe_o[1] && data_o[1] == $past(cmd_sh[31]))
        else $error("request pin not driving");
    chk_serial_float: assert property ( // R14
        $past(st) == cdp_pkg::CDP_LOAD && scheme != cdp_pkg::CDP_ACTIVE_SERIAL_SCHEME
        |-> data_oe_o == 16'h0000)
        else $error("data pin driven during load");
    chk_pin0_input: assert property ( // R11
        $past(st) == cdp_pkg::CDP_USER && scheme == cdp_pkg::CDP_ACTIVE_SERIAL_SCHEME
        |-> !data_oe_o[0])
        else $error("pin zero driven after active serial");
    chk_flag_release: assert property ( // R17
        $rose(st == cdp_pkg::CDP_USER) |-> $past(load_done_i) ##1 !config_complete_flag_oe_o)
        else $error("flag released without clean load");
    chk_scheme_fixed: assert property ( // R18
        st == cdp_pkg::CDP_LOAD && $past(st) == cdp_pkg::CDP_LOAD |-> $stable(scheme))
        else $error("scheme changed during load");
    chk_stall_holds: assert property ( // R2
        stall && st == cdp_pkg::CDP_LOAD |=> $stable(clk_lvl))
        else $error("clock moved while stalled");

    cov_passive_load: cover property (
        st == cdp_pkg::CDP_LOAD && !is_active && link_evt);
    cov_active_serial_byte: cover property (
        rise && cmd_cnt == cdp_pkg::CMD_LEN && as_cnt == 3'h7);
    cov_stall: cover property (stall ##1 stall);
    cov_user_mode: cover property ($rose(st == cdp_pkg::CDP_USER));

endmodule : cdp_config_pins

// ===== cdp_host_model.sv
// ****************************************
// Host that clocks bytes into a passive load
// ****************************************
module cdp_host_model (
    output logic link_clk_o,
    output logic [15:0] data_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // clock parked low
    // Link clock stands low outside frames
    initial begin
        link_clk_o = 1'b0;
        data_o = 16'h0000;
    end
    // bit zero serially LSB first, or a byte per edge
    task automatic send_byte(input logic [7:0] value, input logic wide);
        for (int i = 0; i < (wide ? 1 : 8); i++) begin
            data_o = wide ? {8'h00, value} : {15'h0000, value[i]};
            #62.5 link_clk_o = 1'b1;
            #62.5 link_clk_o = 1'b0;
        end
        // Released lines show the inverse, never a stale copy
        data_o = ~data_o;
    endtask : send_byte
endmodule : cdp_host_model

// ===== test_config_data_pin_interface.sv
module test_config_data_pin_interface;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [1:0] scheme = 2'h0;
    logic start = 1'b0;
    logic done = 1'b0;
    logic dual = 1'b0;
    logic uclk_en = 1'b0;
    logic [15:0] uoe = 16'h0000;
    logic ready = 1'b0;
    logic link_clk;
    logic clk_oe;
    logic flag_oe;
    logic valid;
    logic [15:0] pins;
    logic [15:0] data_oe;
    cdp_pkg::cdp_word_type word;
    logic [15:0] dout;
    logic config_data_clock, flag, ovr, load;
    int bad_count = 0;
    int comparisons = 0;
    cdp_config_pins u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .config_data_clock_i(link_clk),
        .scheme_i(scheme), .config_start_i(start), .load_done_i(done),
        .dual_purpose_user_i(dual), .user_clock_en_i(uclk_en), .user_clock_i(uclk_en),
        .user_data_out_i(16'h00a5), .user_data_oe_i(uoe), .data_i(pins),
        .config_data_clock_o(config_data_clock), .config_data_clock_oe_o(clk_oe), .data_o(dout),
        .data_oe_o(data_oe), .config_complete_flag_o(flag),
        .config_complete_flag_oe_o(flag_oe), .word_valid_o(valid), .word_ready_i(ready),
        .word_o(word), .overrun_o(ovr), .loading_o(load));
    cdp_host_model u_host (.link_clk_o(link_clk), .data_o(pins));
    // Core clock, 20 ns
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    task automatic check(input logic [16:0] got, input logic [16:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // Reset with a new strap, then one start pulse
    task automatic begin_load(input logic [1:0] s);
        nrst_i <= 1'b0;
        scheme <= s;
        done <= 1'b0;
        repeat (10) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        start <= 1'b1;
        @(posedge clk_i);
        start <= 1'b0;
        repeat (4) @(posedge clk_i);
        // Two idle link edges fill the enable crossing; a third would be taken
        for (int i = 0; i < 2; i++) u_host.send_byte(8'h00, 1'b1);
        @(posedge clk_i);
    endtask : begin_load
    // Bounded wait for a word, then one accept
    task automatic take_word(input logic [16:0] exp);
        #1;
        for (int n = 0; n < 200 && valid !== 1'b1; n++) begin
            @(posedge clk_i);
            #1;
        end
        check({16'h0000, valid}, 17'h00001);
        check(word, exp);
        @(posedge clk_i) ready <= 1'b1;
        @(posedge clk_i) ready <= 1'b0;
    endtask : take_word
    task automatic test_serial;
        begin_load(2'h0);
        check({1'b0, data_oe}, 17'h00000);
        check({14'h0000, flag, load, flag_oe}, 17'h00003);
        u_host.send_byte(8'ha5, 1'b0);
        u_host.send_byte(8'h3c, 1'b0);
        take_word({16'h00a5, 1'b0});
        take_word({16'h003c, 1'b0});
    endtask : test_serial
    task automatic test_parallel;
        begin_load(2'h1);
        // Two fill the buffer, the third waits and the fourth replaces it
        u_host.send_byte(8'h81, 1'b1);
        u_host.send_byte(8'h7e, 1'b1);
        u_host.send_byte(8'h33, 1'b1);
        u_host.send_byte(8'h44, 1'b1);
        repeat (6) @(posedge clk_i);
        check({16'h0000, ovr}, 17'h00001);
        take_word({16'h0081, 1'b0});
        take_word({16'h007e, 1'b0});
        take_word({16'h0044, 1'b0});
        dual <= 1'b1;
        uoe <= 16'h00ff;
        done <= 1'b1;
        repeat (4) @(posedge clk_i);
        check({14'h0000, flag, load, flag_oe}, 17'h00000);
        check({16'h0000, clk_oe}, 17'h00000);
        check({1'b0, data_oe}, 17'h000ff);
        check({1'b0, dout}, 17'h000a5);
        u_host.send_byte(8'h55, 1'b1);
        repeat (10) @(posedge clk_i);
        check({16'h0000, valid}, 17'h00000);
    endtask : test_parallel
    task automatic test_active_serial;
        dual <= 1'b0;
        uoe <= 16'h0000;
        begin_load(2'h2);
        check({16'h0000, clk_oe}, 17'h00001);
        check({15'h0000, data_oe[1:0]}, 17'h00002);
        uclk_en <= 1'b1;
        uoe <= 16'h0003;
        done <= 1'b1;
        repeat (4) @(posedge clk_i);
        check({15'h0000, clk_oe, config_data_clock}, 17'h00003);
        check({15'h0000, data_oe[1:0]}, 17'h00002);
    endtask : test_active_serial
    // Words from steady pins once older words are drained
    task automatic test_active_parallel;
        begin_load(2'h3);
        check({16'h0000, clk_oe}, 17'h00001);
        u_host.send_byte(8'h5a, 1'b1);
        @(posedge clk_i) ready <= 1'b1;
        repeat (40) @(posedge clk_i);
        ready <= 1'b0;
        repeat (40) @(posedge clk_i);
        take_word({16'hffa5, 1'b1});
        take_word({16'hffa5, 1'b1});
        @(posedge clk_i);
        ready <= 1'b1;
        done <= 1'b1;
        repeat (8) @(posedge clk_i);
        check({1'b0, data_oe}, 17'h00003);
    endtask : test_active_parallel
    task automatic test_done;
        $display("mismatches %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done
    // Main sequence
    initial begin
        test_serial();
        test_parallel();
        test_active_serial();
        test_active_parallel();
        test_done();
    end
    // Watchdog well past the few hundred cycles needed
    initial begin
        #1_000_000;
        bad_count++;
        test_done();
    end
endmodule : test_config_data_pin_interface
